// ### hw/pst_sequencer.sv
// Purpose: Program sequencer with return stack, table reads and data map.
// Assumes: Decoder issues one op per instruction cycle; AXI4-Lite slave.
// Notes: Bus writes win over interrupts, which win over decoder ops.
// Function
// [RULE1] Flow change inserts one dummy cycle.
// [RULE2] Reset loads program counter with zero.
// [RULE3] External interrupt vectors to 004H.
// [RULE4] First timer overflow vectors to 008H.
// [RULE5] Second timer overflow vectors to 00CH.
// [RULE6] USB interrupt vectors to 010H.
// [RULE7] First serial interrupt vectors to 014H.
// [RULE8] Second serial interrupt vectors to 018H.
// [RULE9] Program memory 4096 by 15 bits.
// [RULE10] Current page uses counter upper bits.
// [RULE11] High option uses both table pointers.
// [RULE12] Last page forces upper bits ones.
// [RULE13] Low byte to memory, rest high.
// [RULE14] Table read takes two cycles.
// [RULE15] Six hidden entries of counter values.
// [RULE16] Call pushes, return restores counter.
// [RULE17] Full stack withholds interrupt acknowledge.
// [RULE18] Call on full stack drops oldest.
// [RULE19] Unimplemented low reads zero; RAM 40H-FFH.
// [RULE20] Addresses 00H/02H go through pointers.
// [RULE21] Pointer at 00H/02H reads zero, ignores writes.
// [RULE22] Accumulator at 05H carries memory moves.
// [RULE23] Counter low byte write jumps in page.
// [RULE24] Accept clears flag and global enable.
// [RULE25] Lowest vector wins among pending requests.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module pst_sequencer
  import pst_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Decoder op port.
  input wire logic opValid,
  input wire pst_op_t opCode,
  input wire logic [11:0] opTarget,
  input wire logic [7:0] opAddr,
  input wire logic [2:0] opBit,
  output logic opReady,
  // Fetch side.
  output logic [11:0] pc,
  output logic [14:0] instrWord,
  output logic dummyCycle,
  // Interrupt request pulses from the peripherals.
  input wire logic [5:0] irqEvent,
  // AXI4-Lite write channels.
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  pst_state_t state;
  logic [11:0] next_pc;
  logic [14:0] rom [ROM_WORDS];
  logic [7:0] ram [RAM_BASE:RAM_TOP];
  logic [7:0] ptrA, ptrB, accum, lookLow, lookHigh;
  logic [6:0] lookRes;
  logic [11:0] stack [6];
  logic [2:0] topPtr, depth;
  logic [11:0] stackTop;
  logic [5:0] flags, enables, pend;
  logic globalEn, highOpt;
  logic [11:0] progAddr;
  logic [11:0] tableAddr;
  logic [7:0] tableDest;
  logic [14:0] tableWord;
  logic busWrGo, busWrData, wrEn, pcJump, irqTake, opTake, flowOp, tableOp;
  logic [2:0] irqSel;
  logic [9:0] wIdx, rIdx;
  logic [7:0] wrRaw, wrData, wrEa;
  logic [11:0] pushVal;
  logic push, pop, stackFull;

  // Map 00H and 02H onto the location held in the matching pointer.
  function automatic logic [7:0] effAddr(input logic [7:0] raw);
    // [RULE20] indirect address select
    if (raw == IND_A) begin
      return ptrA;
    end
    if (raw == IND_B) begin
      return ptrB;
    end
    return raw;
  endfunction

  // Read one data byte; indirect ports that land on 00H/02H read zero.
  function automatic logic [7:0] dataRead(input logic [7:0] raw);
    logic [7:0] ea;
    ea = effAddr(raw);
    // [RULE19] [RULE21] zero for holes
    unique case (ea)
      PTR_A: return ptrA;
      PTR_B: return ptrB;
      ACCUM: return accum;
      PC_LOW: return pc[7:0];
      LOOK_LOW: return lookLow;
      LOOK_RES: return {1'b0, lookRes};
      LOOK_HIGH: return lookHigh;
      default: return (ea >= RAM_BASE) ? ram[ea] : BYTE_ZERO;
    endcase
  endfunction

  // Bus writes wait for the run state so table writes never collide.
  assign wIdx = awaddr[11:2];
  assign rIdx = araddr[11:2];
  assign busWrGo = awvalid && wvalid && !bvalid && (state == ST_RUN);
  assign busWrData = busWrGo && (wIdx[9:8] == 2'h0) && wstrb[0];
  assign awready = busWrGo;
  assign wready = busWrGo;
  assign arready = !rvalid;

  // Interrupt acceptance; the bus has priority so only one writer acts.
  assign pend = flags & enables;
  assign stackFull = (depth == STACK_DEPTH);
  // [RULE17] withhold when stack full
  assign irqTake = (state == ST_RUN) && !busWrGo && globalEn && (|pend) && !stackFull;
  assign opReady = (state == ST_RUN) && !busWrGo && !irqTake;
  assign opTake = opValid && opReady;
  assign flowOp = (opCode == OP_JUMP) || (opCode == OP_CALL) || (opCode == OP_SKIP) ||
                  (opCode == OP_RETURN_SUB) || (opCode == OP_RETURN_INT);
  assign tableOp = (opCode == OP_LOOKUP_CUR) || (opCode == OP_LOOKUP_LAST);
  assign dummyCycle = (state == ST_DUMMY);

  // Priority encoder for pending requests.
  always_comb begin
    irqSel = 3'h0;
    // [RULE25] lowest vector first
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        irqSel = 3'(i);
      end
    end
  end

  // Single data write port shared by bus, table read and decoder ops.
  always_comb begin
    wrEn = 1'b0;
    wrRaw = BYTE_ZERO;
    wrData = BYTE_ZERO;
    if (busWrData) begin
      wrEn = 1'b1;
      wrRaw = wIdx[7:0];
      wrData = wdata[7:0];
    end else if (state == ST_TABLE) begin
      // [RULE13] low byte to memory
      wrEn = 1'b1;
      wrRaw = tableDest;
      wrData = tableWord[7:0];
    end else if (opTake) begin
      unique case (opCode)
        // [RULE22] move through accumulator
        OP_STORE_ACCUM: begin
          wrEn = 1'b1;
          wrRaw = opAddr;
          wrData = accum;
        end
        // [RULE19] bit set support
        OP_BIT_SET: begin
          wrEn = 1'b1;
          wrRaw = opAddr;
          wrData = dataRead(opAddr) | (8'h01 << opBit);
        end
        OP_BIT_CLEAR: begin
          wrEn = 1'b1;
          wrRaw = opAddr;
          wrData = dataRead(opAddr) & ~(8'h01 << opBit);
        end
        default: wrEn = 1'b0;
      endcase
    end
  end

  assign wrEa = effAddr(wrRaw);
  assign pcJump = wrEn && (wrEa == PC_LOW);

  // Data registers and general RAM; writes landing on 00H/02H vanish.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptrA <= BYTE_ZERO;
      ptrB <= BYTE_ZERO;
      lookLow <= BYTE_ZERO;
      lookHigh <= BYTE_ZERO;
    end else if (wrEn) begin
      // [RULE21] write to hole ignored
      unique case (wrEa)
        PTR_A: ptrA <= wrData;
        PTR_B: ptrB <= wrData;
        LOOK_LOW: lookLow <= wrData;
        LOOK_HIGH: lookHigh <= wrData;
        default: begin
          if (wrEa >= RAM_BASE) begin
            ram[wrEa] <= wrData;
          end
        end
      endcase
    end
  end

  // Accumulator takes plain writes and memory loads.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accum <= BYTE_ZERO;
    end else if (wrEn && wrEa == ACCUM) begin
      accum <= wrData;
    end else if (opTake && opCode == OP_LOAD_ACCUM) begin
      // [RULE22] load into accumulator
      accum <= dataRead(opAddr);
    end
  end

  // Next program counter.
  always_comb begin
    next_pc = pc;
    if (pcJump) begin
      // [RULE23] short jump in page
      next_pc = {pc[11:8], wrData};
    end else if (irqTake) begin
      // [RULE3] [RULE4] [RULE5] vector select
      // [RULE6] [RULE7] [RULE8] vector select
      next_pc = VECTOR[irqSel];
    end else if (opTake) begin
      unique case (opCode)
        OP_JUMP, OP_CALL: next_pc = opTarget;
        // [RULE16] restore from stack
        OP_RETURN_SUB, OP_RETURN_INT: next_pc = stackTop;
        OP_SKIP: next_pc = pc + PC_SKIP;
        default: next_pc = pc + PC_STEP;
      endcase
    end
  end

  // Program counter and fetched word; the ROM read is registered here.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // [RULE2] start at zero
      pc <= RESET_VECTOR;
      instrWord <= rom[RESET_VECTOR];
    end else begin
      pc <= next_pc;
      instrWord <= rom[next_pc];
    end
  end

  // Sequencer state.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          // [RULE1] dummy after transfer
          if (pcJump || irqTake || (opTake && flowOp)) begin
            state <= ST_DUMMY;
          end else if (opTake && tableOp) begin
            // [RULE14] second table cycle
            state <= ST_TABLE;
          end
        end
        ST_TABLE: state <= pcJump ? ST_DUMMY : ST_RUN;
        ST_DUMMY: state <= ST_RUN;
      endcase
    end
  end

  // Table address is latched in the first cycle, used in the second.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tableAddr <= RESET_VECTOR;
      tableDest <= BYTE_ZERO;
    end else if (opTake && tableOp) begin
      tableDest <= opAddr;
      if (opCode == OP_LOOKUP_LAST) begin
        // [RULE12] force last page
        tableAddr <= {LAST_PAGE, lookLow};
      end else if (highOpt) begin
        // [RULE11] both table pointers
        tableAddr <= {lookHigh[3:0], lookLow};
      end else begin
        // [RULE10] current page bits
        tableAddr <= {pc[11:8], lookLow};
      end
    end
  end

  // [RULE9] program memory read
  assign tableWord = rom[tableAddr];

  // Upper table bits; software cannot write this register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lookRes <= 7'h00;
    end else if (state == ST_TABLE) begin
      // [RULE13] upper bits kept
      lookRes <= tableWord[14:8];
    end
  end

  // Program memory is loaded word by word through the bus.
  always_ff @(posedge clk) begin
    if (busWrGo && wIdx == IDX_PROG_DATA && wstrb[0]) begin
      rom[progAddr] <= wdata[14:0];
    end
  end

  // Return stack as a ring, so an overflowing push drops the oldest entry.
  assign push = irqTake || (opTake && opCode == OP_CALL);
  assign pop = opTake && (opCode == OP_RETURN_SUB || opCode == OP_RETURN_INT);
  assign pushVal = irqTake ? pc : pc + PC_STEP;
  assign stackTop = stack[topPtr];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      topPtr <= STACK_LAST;
      depth <= STACK_EMPTY;
    end else if (push) begin
      // [RULE16] [RULE18] push and wrap
      topPtr <= (topPtr == STACK_LAST) ? STACK_EMPTY : topPtr + STACK_ONE;
      stack[(topPtr == STACK_LAST) ? STACK_EMPTY : topPtr + STACK_ONE] <= pushVal;
      depth <= stackFull ? depth : depth + STACK_ONE;
    end else if (pop) begin
      // [RULE15] hidden index only
      topPtr <= (topPtr == STACK_EMPTY) ? STACK_LAST : topPtr - STACK_ONE;
      depth <= (depth == STACK_EMPTY) ? depth : depth - STACK_ONE;
    end
  end

  // Request flags; a new event beats any clear in the same cycle.
  generate
    for (genvar i = 0; i < IRQ_N; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          flags[i] <= 1'b0;
        end else if (irqEvent[i]) begin
          flags[i] <= 1'b1;
        end else if ((irqTake && irqSel == 3'(i)) ||
                     (busWrGo && wIdx == IDX_INT_FLAG && wstrb[0] && wdata[i])) begin
          // [RULE24] clear accepted flag
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Global and per-source enables.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      globalEn <= 1'b0;
      enables <= 6'h00;
    end else if (busWrGo && wIdx == IDX_INT_CTRL && wstrb[0]) begin
      globalEn <= wdata[0];
      enables <= wdata[6:1];
    end else if (irqTake) begin
      // [RULE24] block further interrupts
      globalEn <= 1'b0;
    end else if (opTake && opCode == OP_RETURN_INT) begin
      globalEn <= 1'b1;
    end
  end

  // Configuration and program load address.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      highOpt <= 1'b0;
      progAddr <= RESET_VECTOR;
    end else if (busWrGo && wstrb[0]) begin
      if (wIdx == IDX_CFG) begin
        highOpt <= wdata[0];
      end
      if (wIdx == IDX_PROG_ADDR) begin
        progAddr <= wdata[11:0];
      end
    end
  end

  // Write response; unmapped indices answer with a slave error.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (busWrGo) begin
      bvalid <= 1'b1;
      bresp <= (wIdx > IDX_INT_FLAG) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read response, one cycle after the address is taken.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= (rIdx > IDX_INT_FLAG) ? RESP_SLVERR : RESP_OKAY;
      rdata <= 32'h0000_0000;
      if (rIdx[9:8] == 2'h0) begin
        rdata[7:0] <= dataRead(rIdx[7:0]);
      end else if (rIdx == IDX_CFG) begin
        rdata[0] <= highOpt;
      end else if (rIdx == IDX_PROG_ADDR) begin
        rdata[11:0] <= progAddr;
      end else if (rIdx == IDX_PROG_DATA) begin
        rdata[14:0] <= rom[progAddr];
      end else if (rIdx == IDX_STATUS) begin
        rdata[11:0] <= pc;
        rdata[STATUS_DEPTH_LSB +: 3] <= depth;
      end else if (rIdx == IDX_INT_CTRL) begin
        rdata[6:0] <= {enables, globalEn};
      end else if (rIdx == IDX_INT_FLAG) begin
        rdata[5:0] <= flags;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks kept beside the logic.
  property p_reset_pc;
    @(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> pc == RESET_VECTOR;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset"); // [RULE2]

  property p_dummy;
    @(posedge clk) disable iff (!reset_n)
      opTake && flowOp |=> dummyCycle && !opReady ##1 state == ST_RUN;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no single dummy cycle"); // [RULE1]

  property p_vector;
    @(posedge clk) disable iff (!reset_n)
      irqTake && !pcJump |=> pc == VECTOR[$past(irqSel)] && depth != STACK_EMPTY;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector"); // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]

  property p_full_hold;
    @(posedge clk) disable iff (!reset_n)
      stackFull && (|pend) && !pcJump && !opTake |=> pc == $past(pc);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("acknowledged on full stack"); // [RULE17]

  property p_two_cycles;
    @(posedge clk) disable iff (!reset_n)
      opTake && tableOp |=> state == ST_TABLE && !opReady ##1 state != ST_TABLE;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("table read not two cycles"); // [RULE14]

  property p_last_page;
    @(posedge clk) disable iff (!reset_n)
      opTake && opCode == OP_LOOKUP_LAST |=> tableAddr == {LAST_PAGE, $past(lookLow)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong"); // [RULE12]

  property p_overflow;
    @(posedge clk) disable iff (!reset_n)
      push && stackFull |=> stackFull && stackTop == $past(pushVal);
  endproperty
  a_overflow: assert property (p_overflow) else $error("full push lost"); // [RULE18]

  property p_return;
    @(posedge clk) disable iff (!reset_n)
      pop && !pcJump |=> pc == $past(stackTop);
  endproperty
  a_return: assert property (p_return) else $error("return address wrong"); // [RULE16]

  property p_accept_clear;
    @(posedge clk) disable iff (!reset_n)
      irqTake |=> !globalEn && !irqTake [*2];
  endproperty
  a_accept_clear: assert property (p_accept_clear) else $error("global enable kept"); // [RULE24]

  property p_hole_zero;
    @(posedge clk) disable iff (!reset_n)
      arvalid && arready && rIdx == {2'h0, IND_B} && (ptrB == IND_A || ptrB == IND_B)
        |=> rdata == 32'h0000_0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("indirect hole not zero"); // [RULE21]

endmodule

// ### hw/pst_pkg.sv
// Purpose: Shared constants and types for the program sequencer core.
// Assumes: One instruction cycle per clk; registers sit one per 32-bit word.
// Notes: Register byte address is four times the index below.
package pst_pkg;

  // Program memory and counter geometry.
  localparam int PC_W = 12;
  localparam int ROM_WORDS = 4096;
  localparam int ROM_W = 15;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [11:0] PC_SKIP = 12'h002;
  localparam logic [3:0] LAST_PAGE = 4'hf;

  // Interrupt vectors, lowest index has the highest priority.
  localparam int IRQ_N = 6;
  localparam logic [11:0] VECTOR [IRQ_N] = '{12'h004, 12'h008, 12'h00c,
                                              12'h010, 12'h014, 12'h018};

  // Return stack.
  localparam logic [2:0] STACK_DEPTH = 3'h6;
  localparam logic [2:0] STACK_LAST = 3'h5;
  localparam logic [2:0] STACK_EMPTY = 3'h0;
  localparam logic [2:0] STACK_ONE = 3'h1;

  // Data memory map (register indices).
  localparam logic [7:0] IND_A = 8'h00;
  localparam logic [7:0] PTR_A = 8'h01;
  localparam logic [7:0] IND_B = 8'h02;
  localparam logic [7:0] PTR_B = 8'h03;
  localparam logic [7:0] ACCUM = 8'h05;
  localparam logic [7:0] PC_LOW = 8'h06;
  localparam logic [7:0] LOOK_LOW = 8'h07;
  localparam logic [7:0] LOOK_RES = 8'h08;
  localparam logic [7:0] LOOK_HIGH = 8'h1f;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam logic [7:0] RAM_TOP = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Control registers beyond the data map (register indices).
  localparam logic [9:0] IDX_CFG = 10'h100;
  localparam logic [9:0] IDX_PROG_ADDR = 10'h101;
  localparam logic [9:0] IDX_PROG_DATA = 10'h102;
  localparam logic [9:0] IDX_STATUS = 10'h103;
  localparam logic [9:0] IDX_INT_CTRL = 10'h104;
  localparam logic [9:0] IDX_INT_FLAG = 10'h105;
  localparam int STATUS_DEPTH_LSB = 16;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_TABLE = 3'h2,
    ST_DUMMY = 3'h4
  } pst_state_t;

  // Operations issued by the instruction decoder.
  typedef enum logic [3:0] {
    OP_NEXT = 4'h0,
    OP_JUMP = 4'h1,
    OP_CALL = 4'h2,
    OP_RETURN_SUB = 4'h3,
    OP_RETURN_INT = 4'h4,
    OP_SKIP = 4'h5,
    OP_LOOKUP_CUR = 4'h6,
    OP_LOOKUP_LAST = 4'h7,
    OP_LOAD_ACCUM = 4'h8,
    OP_STORE_ACCUM = 4'h9,
    OP_BIT_SET = 4'ha,
    OP_BIT_CLEAR = 4'hb
  } pst_op_t;

endpackage

// ### tb/pst_sequencer_bench.sv
// Purpose: Self-checking bench for the program sequencer core.
// Assumes: Registers over AXI4-Lite; decoder ops driven straight at the op port.
// Notes: Response channels stay ready throughout, which the bus permits.
`timescale 1ns/100ps
module pst_sequencer_bench;
  import pst_pkg::*;
  // Design stimulus, all given values at time zero.
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic opValid = 1'b0;
  pst_op_t opCode = OP_NEXT;
  logic [11:0] opTarget = 12'h000;
  logic [7:0] opAddr = 8'h00;
  logic [2:0] opBit = 3'h0;
  logic [5:0] irqEvent = 6'h00;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic bready = 1'b1;
  logic rready = 1'b1;
  // Design outputs and captured answers.
  logic opReady, dummyCycle, awready, wready, bvalid, arready, rvalid;
  logic [11:0] pc, saved;
  logic [14:0] instrWord;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, rsp;
  logic rdy, dum;
  int miscompares = 0;
  int compares = 0;
  // Register map cases: write one place, read back the same place or another.
  typedef struct {logic [9:0] w; logic [7:0] v; logic [9:0] r; logic [31:0] e; logic [1:0] s;}
    pst_row_t;
  pst_row_t rows [10] = '{
    '{10'h040, 8'h5a, 10'h040, 32'h5a, RESP_OKAY}, '{10'h010, 8'hff, 10'h010, 32'h00, RESP_OKAY},
    '{10'h005, 8'hc3, 10'h005, 32'hc3, RESP_OKAY}, '{10'h001, 8'h41, 10'h001, 32'h41, RESP_OKAY},
    '{10'h000, 8'h77, 10'h041, 32'h77, RESP_OKAY}, '{10'h003, 8'h00, 10'h002, 32'h00, RESP_OKAY},
    '{10'h002, 8'h99, 10'h041, 32'h77, RESP_OKAY}, '{10'h008, 8'h11, 10'h008, 32'h00, RESP_OKAY},
    '{10'h006, 8'h55, 10'h103, 32'h55, RESP_OKAY}, '{10'h200, 8'h66, 10'h200, 32'h00, RESP_SLVERR}};

  pst_sequencer dut (
    .clk(clk), .reset_n(reset_n),
    .opValid(opValid), .opCode(opCode), .opTarget(opTarget), .opAddr(opAddr), .opBit(opBit),
    .opReady(opReady), .pc(pc), .instrWord(instrWord), .dummyCycle(dummyCycle),
    .irqEvent(irqEvent),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Both write channels together; a dead slave is caught by the watchdog alone.
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
  endtask

  task automatic rd(input logic [9:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rsp = rresp;
  endtask

  // One decoder op; samples ready and dummy in the cycle after the take.
  task automatic op(input pst_op_t c, input logic [11:0] t, input logic [7:0] a);
    opCode <= c;
    opTarget <= t;
    opAddr <= a;
    opBit <= t[2:0];
    opValid <= 1'b1;
    do @(posedge clk); while (opReady !== 1'b1);
    opValid <= 1'b0;
    @(posedge clk);
    rdy = opReady;
    dum = dummyCycle;
  endtask

  task automatic pulse(input logic [5:0] v);
    irqEvent <= v;
    @(posedge clk);
    irqEvent <= 6'h00;
  endtask

  task automatic waitPc(input logic [11:0] v, input string m);
    int n;
    n = 0;
    do @(posedge clk); while (pc !== v && ++n < 20);
    chk(pc === v, m);
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(pc === RESET_VECTOR && opReady === 1'b1 && dummyCycle === 1'b0, "reset");
    wr(IDX_PROG_ADDR, 32'hf34);
    wr(IDX_PROG_DATA, 32'h5abc);
    wr(IDX_PROG_ADDR, 32'h334);
    wr(IDX_PROG_DATA, 32'h1234);
    rd(IDX_PROG_DATA);
    chk(d[14:0] === 15'h1234, "rom word");
    for (int i = 0; i < 10; i++) begin
      wr(rows[i].w, 32'(rows[i].v));
      chk(rsp === rows[i].s, "write resp");
      rd(rows[i].r);
      chk(d === rows[i].e && rsp === rows[i].s, "map");
    end
    op(OP_BIT_SET, 12'h007, 8'h40);
    op(OP_BIT_CLEAR, 12'h001, 8'h40);
    rd(10'h040);
    chk(d === 32'hd8, "bit ops");
    op(OP_STORE_ACCUM, 12'h000, 8'h44);
    rd(10'h044);
    chk(d === 32'hc3, "store accumulator");
    op(OP_LOAD_ACCUM, 12'h000, 8'h40);
    rd(10'h005);
    chk(d === 32'hd8, "load accumulator");
    saved = pc;
    op(OP_SKIP, 12'h000, 8'h00);
    chk(pc === saved + 12'h002 && dum === 1'b1, "skip");
    for (int k = 0; k < 6; k++) begin
      saved = 12'(12'h100 + 16 * k);
      op(OP_CALL, saved, 8'h00);
      chk(pc === saved && rdy === 1'b0 && dum === 1'b1, "call");
    end
    wr(IDX_INT_CTRL, 32'h3);
    pulse(6'h01);
    repeat (4) @(posedge clk);
    chk(pc === 12'h150, "full stack withholds");
    rd(IDX_INT_FLAG);
    chk(d[0] === 1'b1, "flag kept");
    op(OP_CALL, 12'h160, 8'h00);
    op(OP_RETURN_SUB, 12'h000, 8'h00);
    chk(pc === 12'h151, "return newest");
    waitPc(VECTOR[0], "served after pop");
    op(OP_RETURN_INT, 12'h000, 8'h00);
    chk(pc === 12'h151, "interrupt return");
    for (int k = 4; k >= 0; k--) begin
      op(OP_RETURN_SUB, 12'h000, 8'h00);
      chk(pc === 12'(12'h101 + 16 * k), "ring order");
    end
    for (int i = 0; i < 6; i++) begin
      wr(IDX_INT_CTRL, 32'(1 | (2 << i)));
      saved = pc;
      pulse(6'(1 << i));
      waitPc(VECTOR[i], "vector");
      rd(IDX_INT_CTRL);
      chk(d[0] === 1'b0, "global enable cleared");
      rd(IDX_INT_FLAG);
      chk(d[i] === 1'b0, "flag cleared");
      op(OP_RETURN_INT, 12'h000, 8'h00);
      chk(pc === saved && dum === 1'b1, "resume");
    end
    wr(IDX_INT_CTRL, 32'h7f);
    pulse(6'h3f);
    waitPc(VECTOR[0], "first pick");
    op(OP_RETURN_INT, 12'h000, 8'h00);
    waitPc(VECTOR[1], "second pick");
    wr(IDX_INT_FLAG, 32'h3f);
    wr(IDX_INT_CTRL, 32'h0);
    op(OP_RETURN_INT, 12'h000, 8'h00);
    op(OP_JUMP, 12'h334, 8'h00);
    chk(pc === 12'h334 && instrWord === 15'h1234, "jump fetch");
    wr(10'h007, 32'h34);
    op(OP_LOOKUP_CUR, 12'h000, 8'h40);
    chk(rdy === 1'b0 && dum === 1'b0, "two cycles");
    rd(10'h040);
    chk(d === 32'h34, "current page low");
    rd(10'h008);
    chk(d === 32'h12, "result high");
    wr(10'h006, 32'h20);
    rd(IDX_STATUS);
    chk(d[11:0] === 12'h320, "page jump");
    op(OP_LOOKUP_LAST, 12'h000, 8'h41);
    rd(10'h041);
    chk(d === 32'hbc, "last page low");
    rd(10'h008);
    chk(d === 32'h5a, "last page high");
    wr(10'h01f, 32'h0f);
    wr(IDX_CFG, 32'h1);
    op(OP_LOOKUP_CUR, 12'h000, 8'h42);
    rd(10'h042);
    chk(d === 32'hbc, "both pointers");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(pc === RESET_VECTOR && dummyCycle === 1'b0 && opReady === 1'b1, "re-reset");
    rd(IDX_STATUS);
    chk(d === 32'h0, "depth and pc cleared");
    stop_test();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    #(50 * 20000);
    miscompares++;
    stop_test();
  end
endmodule
